// >>> pkg/cap_counter_pkg.sv
package cap_counter_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_MAIN = 6'h0a;
   localparam logic [5:0] IDX_CNTH = 6'h0c;
   localparam logic [5:0] IDX_CNTL = 6'h0d;
   localparam logic [5:0] IDX_WRAPH = 6'h0e;
   localparam logic [5:0] IDX_WRAPL = 6'h0f;
   localparam logic [5:0] IDX_CH0C = 6'h10;
   localparam logic [5:0] IDX_CH0H = 6'h11;
   localparam logic [5:0] IDX_CH0L = 6'h12;
   localparam logic [5:0] IDX_CH1C = 6'h13;
   localparam logic [5:0] IDX_CH1H = 6'h14;
   localparam logic [5:0] IDX_CH1L = 6'h15;
   localparam logic [5:0] IDX_ISTAT = 6'h16;
   localparam logic [5:0] IDX_IMASK = 6'h17;
   localparam int ADDR_LSB = 2;

   // field positions, main control and channel control
   localparam int B_FLAG = 7;
   localparam int B_IE = 6;
   localparam int B_HALT = 5;
   localparam int B_CRST = 4;
   localparam int B_LINK = 5;
   localparam int B_MSA = 4;
   localparam int B_ELSB = 3;
   localparam int B_ELSA = 2;
   localparam int B_TOV = 1;
   localparam int B_MAX = 0;
   localparam int I_OVF = 0;
   localparam int I_CH0 = 1;

   // reset values and masks
   localparam logic [15:0] WRAP_RST = 16'hffff;
   localparam logic [6:0] CH1_WMASK = 7'h5f;
   localparam logic [2:0] PS_EXT = 3'h7;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;
endpackage : cap_counter_pkg

// >>> design/two_channel_capture_counter.sv
`timescale 1ns/10ps
module two_channel_capture_counter (
   input wire logic clk, // bus clock, 125 MHz
   input wire logic rstn, // async reset, active low
   input wire cap_counter_pkg::axil_req_t axiReq, // lite master in
   output cap_counter_pkg::axil_rsp_t axiRsp, // lite slave out
   input wire logic [1:0] chanPinIn, // pin levels, async
   output logic [1:0] chanPinOut, // pin drive values
   output logic [1:0] chanPinOeN, // low while driving pin
   input wire logic extCountClock, // counter clock pin, async
   output logic irq // level interrupt
);
   import cap_counter_pkg::*;

   typedef struct packed {
      logic [2:0] ps;
      logic halt;
      logic ovfIe;
      logic ovfF;
      logic [15:0] wrap;
      logic [15:0] cnt;
      logic [5:0] div;
      logic [1:0][7:0] chCtl;
      logic [1:0][15:0] chVal;
      logic [1:0] pin;
      logic linkAct;
      logic linkNext;
      logic [2:0] iStat;
      logic [2:0] iMask;
      logic [2:0] extSy;
      logic [1:0][2:0] pinSy;
      logic awHave;
      logic [5:0] awIdx;
      logic wHave;
      logic [7:0] wByte;
      logic wEn;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [5:0] rIdx;
   } state_t;

   // reset values: counter zero, modulo ones, stop set
   localparam state_t ST_RST = '{halt: 1'b1, wrap: WRAP_RST, default: '0};

   state_t s_r;
   state_t s_nxt;
   logic extEdge;
   logic [5:0] psMask;
   logic tickNow;
   logic runNow;
   logic atWrap;
   logic ovfNow;
   logic rstWr;
   logic [15:0] cntNew;
   logic link;
   logic [1:0] outMode;
   logic [1:0] active;
   logic [1:0] capEv;
   logic [1:0] cmpEv;
   logic [1:0][15:0] cmpVal;
   logic doWr;

   // edge match: bit 0 rising, bit 1 falling, both for either edge
   function automatic logic edgeHit(input logic [1:0] els,
                                    input logic now, input logic was);
      edgeHit = (els[0] & now & ~was) | (els[1] & ~now & was);
   endfunction : edgeHit

   // pin action on compare: toggle, clear or set
   function automatic logic pinAct(input logic [1:0] els,
                                   input logic cur);
      case (els)
         2'b01: pinAct = ~cur;
         2'b10: pinAct = 1'b0;
         2'b11: pinAct = 1'b1;
         default: pinAct = cur;
      endcase
   endfunction : pinAct

   function automatic logic isMapped(input logic [5:0] idx);
      isMapped = (idx >= IDX_MAIN) && (idx <= IDX_IMASK)
                 && (idx != 6'h0b);
   endfunction : isMapped

   // read data of one register; unused upper bits read zero
   function automatic logic [7:0] rdByte(input state_t s,
                                         input logic [5:0] idx);
      case (idx)
         // reset bit and bits 4:3 read zero
         IDX_MAIN: rdByte = {s.ovfF, s.ovfIe, s.halt, 2'b00, s.ps};
         IDX_CNTH: rdByte = s.cnt[15:8];
         IDX_CNTL: rdByte = s.cnt[7:0];
         IDX_WRAPH: rdByte = s.wrap[15:8];
         IDX_WRAPL: rdByte = s.wrap[7:0];
         IDX_CH0C: rdByte = s.chCtl[0];
         IDX_CH0H: rdByte = s.chVal[0][15:8];
         IDX_CH0L: rdByte = s.chVal[0][7:0];
         IDX_CH1C: rdByte = s.chCtl[1];
         IDX_CH1H: rdByte = s.chVal[1][15:8];
         IDX_CH1L: rdByte = s.chVal[1][7:0];
         IDX_ISTAT: rdByte = {5'h00, s.iStat};
         IDX_IMASK: rdByte = {5'h00, s.iMask};
         default: rdByte = 8'h00;
      endcase
   endfunction : rdByte

   // all next-state logic: counting first, then writes, then events
   always_comb begin
      s_nxt = s_r;
      // pin rate at most half the bus clock, so the sync sees edges
      s_nxt.extSy = {s_r.extSy[1], s_r.extSy[0], extCountClock};
      extEdge = s_r.extSy[1] & ~s_r.extSy[2];
      s_nxt.div = s_r.div + 6'h01;
      psMask = 6'((7'h01 << s_r.ps) - 7'h01);
      tickNow = (s_r.ps == PS_EXT) ? extEdge
                : ((s_r.div & psMask) == psMask);
      runNow = tickNow & ~s_r.halt;
      atWrap = (s_r.cnt == s_r.wrap);
      // count up, back to zero after the wrap value
      cntNew = atWrap ? 16'h0000 : s_r.cnt + 16'h0001;
      ovfNow = runNow & atWrap;
      if (runNow) begin
         s_nxt.cnt = cntNew;
      end
      link = s_r.chCtl[0][B_LINK];
      // last written pair takes over at overflow
      if (ovfNow & link) begin
         s_nxt.linkAct = s_r.linkNext;
      end
      for (int i = 0; i < 2; i++) begin
         s_nxt.pinSy[i] = {s_r.pinSy[i][1], s_r.pinSy[i][0], chanPinIn[i]};
         // per-channel mode; linked pair acts as output compare
         outMode[i] = s_r.chCtl[i][B_MSA] | ((i == 0) & link);
         active[i] = (i == 0) | ~link;
         capEv[i] = active[i] & ~outMode[i]
                    & edgeHit(s_r.chCtl[i][B_ELSB:B_ELSA],
                              s_r.pinSy[i][1], s_r.pinSy[i][2]);
         cmpVal[i] = ((i == 0) & link & s_r.linkAct) ? s_r.chVal[1]
                     : s_r.chVal[i];
         cmpEv[i] = active[i] & outMode[i] & runNow
                    & (cntNew == cmpVal[i]);
         // overflow toggle; full duty holds the pin high
         if (active[i] & outMode[i] & ovfNow & s_r.chCtl[i][B_TOV]) begin
            s_nxt.pin[i] = s_r.chCtl[i][B_MAX] | ~s_r.pin[i];
         end
         // compare action, after the overflow toggle
         if (cmpEv[i] & ~s_r.chCtl[i][B_MAX]) begin
            s_nxt.pin[i] = pinAct(s_r.chCtl[i][B_ELSB:B_ELSA],
                                  s_nxt.pin[i]);
         end
      end

      // bus slave: address and data taken in either order
      if (axiReq.awvalid & ~s_r.awHave) begin
         s_nxt.awHave = 1'b1;
         s_nxt.awIdx = axiReq.awaddr[7:ADDR_LSB];
      end
      if (axiReq.wvalid & ~s_r.wHave) begin
         s_nxt.wHave = 1'b1;
         s_nxt.wByte = axiReq.wdata[7:0];
         s_nxt.wEn = axiReq.wstrb[0];
      end
      if (s_r.bvalid & axiReq.bready) begin
         s_nxt.bvalid = 1'b0;
      end
      doWr = s_r.awHave & s_r.wHave & ~s_r.bvalid;
      rstWr = 1'b0;
      if (doWr) begin
         s_nxt.awHave = 1'b0;
         s_nxt.wHave = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = isMapped(s_r.awIdx) ? RESP_OK : RESP_ERR;
      end
      if (doWr & s_r.wEn) begin
         case (s_r.awIdx)
            // stop bit and write-only counter reset
            IDX_MAIN: begin
               if (~s_r.wByte[B_FLAG]) begin
                  s_nxt.ovfF = 1'b0;
               end
               s_nxt.ovfIe = s_r.wByte[B_IE];
               s_nxt.halt = s_r.wByte[B_HALT];
               s_nxt.ps = s_r.wByte[2:0];
               rstWr = s_r.wByte[B_CRST];
            end
            IDX_WRAPH: s_nxt.wrap[15:8] = s_r.wByte;
            IDX_WRAPL: s_nxt.wrap[7:0] = s_r.wByte;
            // flag clears on a zero write only
            IDX_CH0C: begin
               s_nxt.chCtl[0][6:0] = s_r.wByte[6:0];
               if (~s_r.wByte[B_FLAG]) begin
                  s_nxt.chCtl[0][B_FLAG] = 1'b0;
               end
            end
            IDX_CH1C: begin
               s_nxt.chCtl[1][6:0] = s_r.wByte[6:0] & CH1_WMASK;
               if (~s_r.wByte[B_FLAG]) begin
                  s_nxt.chCtl[1][B_FLAG] = 1'b0;
               end
            end
            IDX_CH0H: begin
               s_nxt.chVal[0][15:8] = s_r.wByte;
               s_nxt.linkNext = 1'b0;
            end
            IDX_CH0L: begin
               s_nxt.chVal[0][7:0] = s_r.wByte;
               s_nxt.linkNext = 1'b0;
            end
            IDX_CH1H: begin
               s_nxt.chVal[1][15:8] = s_r.wByte;
               s_nxt.linkNext = 1'b1;
            end
            IDX_CH1L: begin
               s_nxt.chVal[1][7:0] = s_r.wByte;
               s_nxt.linkNext = 1'b1;
            end
            IDX_ISTAT: s_nxt.iStat = s_r.iStat & ~s_r.wByte[2:0];
            IDX_IMASK: s_nxt.iMask = s_r.wByte[2:0];
            default: s_nxt.iMask = s_r.iMask;
         endcase
      end
      // software reset of counter and prescaler beats the tick
      if (rstWr) begin
         s_nxt.cnt = 16'h0000;
         s_nxt.div = 6'h00;
      end

      // read channel; answer one cycle after address is taken
      if (s_r.rvalid & axiReq.rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (axiReq.arvalid & ~s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rIdx = axiReq.araddr[7:ADDR_LSB];
         s_nxt.rdata = rdByte(s_r, axiReq.araddr[7:ADDR_LSB]);
         s_nxt.rresp = isMapped(axiReq.araddr[7:ADDR_LSB]) ? RESP_OK
                       : RESP_ERR;
      end

      // events last so a set beats a same-cycle clear
      if (ovfNow) begin
         s_nxt.ovfF = 1'b1;
         s_nxt.iStat[I_OVF] = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         // latch the counter, capture wins over a write
         if (capEv[i]) begin
            s_nxt.chVal[i] = s_r.cnt;
         end
         if (capEv[i] | cmpEv[i]) begin
            s_nxt.chCtl[i][B_FLAG] = 1'b1;
            s_nxt.iStat[I_CH0 + i] = 1'b1;
         end
      end
   end

   // single state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ready terms may be combinational, data from flops
   always_comb begin
      axiRsp.awready = ~s_r.awHave;
      axiRsp.wready = ~s_r.wHave;
      axiRsp.bvalid = s_r.bvalid;
      axiRsp.bresp = s_r.bresp;
      axiRsp.arready = ~s_r.rvalid;
      axiRsp.rvalid = s_r.rvalid;
      axiRsp.rdata = {24'h000000, s_r.rdata};
      axiRsp.rresp = s_r.rresp;
   end

   // undriven pins stay free for the general port logic
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         chanPinOeN[i] = ~(active[i] & outMode[i]
                           & (s_r.chCtl[i][B_ELSB:B_ELSA] != 2'b00));
      end
      chanPinOut = s_r.pin;
   end

   // masked and enabled status bits form the interrupt
   assign irq = |(s_r.iStat & s_r.iMask
                  & {s_r.chCtl[1][B_IE], s_r.chCtl[0][B_IE], s_r.ovfIe});

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rstn);

   countUp_a: assert property (
      runNow && !atWrap && !rstWr |=> s_r.cnt == $past(s_r.cnt) + 16'h1)
      else $error("counter did not step up");
   wrapZero_a: assert property (
      ovfNow && !rstWr |=> s_r.cnt == 16'h0 && s_r.ovfF && s_r.iStat[0])
      else $error("wrap did not clear counter and set flag");
   haltHold_a: assert property (
      s_r.halt && !rstWr |=> $stable(s_r.cnt))
      else $error("halted counter moved");
   extSource_a: assert property (
      tickNow && s_r.ps == PS_EXT |-> $past(s_r.extSy[0], 1)
      && !s_r.extSy[2])
      else $error("pin clock tick without pin edge");
   readZero_a: assert property (
      s_r.rvalid && s_r.rIdx == IDX_MAIN |-> s_r.rdata[4:3] == 2'b00)
      else $error("main control reserved bits not zero");
   captureLatch_a: assert property (
      capEv[0] |=> s_r.chVal[0] == $past(s_r.cnt))
      else $error("capture did not latch counter");
   captureFlag_a: assert property (
      capEv[1] |=> s_r.chCtl[1][7] ##0 s_r.iStat[2])
      else $error("capture flag not raised");
   setAction_a: assert property (
      cmpEv[0] && s_r.chCtl[0][3:2] == 2'b11 && !s_r.chCtl[0][0]
      |=> chanPinOut[0] == 1'b1)
      else $error("set on compare failed");
   linkBitZero_a: assert property (
      s_r.chCtl[1][5] == 1'b0)
      else $error("channel 1 link bit set");
   linkSwap_a: assert property (
      ovfNow && link |=> s_r.linkAct == $past(s_r.linkNext))
      else $error("linked pair did not swap at overflow");

   cover property (capEv[0]);
   cover property (ovfNow && s_r.chCtl[0][1]);
   cover property (ovfNow && link && s_r.linkNext != s_r.linkAct);
   cover property (cmpEv[1] ##1 irq);
endmodule : two_channel_capture_counter

// >>> verification/pin_partner.sv
`timescale 1ns/10ps
module pin_partner (
   input wire logic clk, // bus clock
   input wire logic [1:0] pinOut, // block drive values
   input wire logic [1:0] pinOeN, // low while block drives
   input wire logic [1:0] evtLevel, // event source levels
   input wire logic extRun, // run the clock pin
   output logic [1:0] pinIn, // resolved pin levels
   output logic extClk // external count clock
);
   logic [1:0] div = 2'h0;
   logic extPh = 1'b0;
   // event source drives a pin only while the block leaves it
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pinIn[i] = pinOeN[i] ? evtLevel[i] : pinOut[i];
      end
   end
   // clock pin below half rate
   // a quarter of the bus rate; the pin stands still between bursts
   always @(posedge clk) begin
      div <= extRun ? div + 2'h1 : 2'h0;
      if (extRun && div[0]) begin
         extPh <= ~extPh;
      end
   end
   // one driver for the pin, starting low
   assign extClk = extPh;
endmodule : pin_partner

// >>> verification/two_channel_capture_counter_tb.sv
`timescale 1ns/10ps
module two_channel_capture_counter_tb;
   import cap_counter_pkg::*;
   logic clk, rstn, extRun, extClk, irq;
   logic [1:0] evtLevel, pinIn, pinOut, pinOeN, rr;
   axil_req_t req;
   axil_rsp_t rsp;
   int errors, tests_run;
   logic [7:0] rv;
   logic [15:0] cnt, ex, dif;
   logic [5:0] rIdx [8] = '{IDX_MAIN, IDX_CNTH, IDX_CNTL, IDX_WRAPH,
      IDX_WRAPL, IDX_CH0C, IDX_CH1C, IDX_IMASK};
   logic [7:0] rVal [8] = '{8'h20, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
      8'h00, 8'h00};
   logic [7:0] actCode [3] = '{8'h1c, 8'h18, 8'h14};

   two_channel_capture_counter two_channel_capture_counter_inst (
      .clk(clk), .rstn(rstn), .axiReq(req), .axiRsp(rsp),
      .chanPinIn(pinIn), .chanPinOut(pinOut), .chanPinOeN(pinOeN),
      .extCountClock(extClk), .irq(irq));
   pin_partner pin_partner_inst (.clk(clk), .pinOut(pinOut),
      .pinOeN(pinOeN), .evtLevel(evtLevel), .extRun(extRun),
      .pinIn(pinIn), .extClk(extClk));

   // free-running bus clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // one lite transfer; each channel released at its own handshake
   task automatic xfer(input bit isWr, input logic [5:0] idx,
         input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      if (isWr) begin
         req.awaddr <= {idx, 2'h0};
         req.wdata <= {24'h0, wd};
         req.wstrb <= 4'hf;
         req.awvalid <= 1'b1;
         req.wvalid <= 1'b1;
         req.bready <= 1'b1;
      end else begin
         req.araddr <= {idx, 2'h0};
         req.arvalid <= 1'b1;
         req.rready <= 1'b1;
      end
      do begin
         @(posedge clk);
         n++;
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!(req.bready && rsp.bvalid) &&
         !(req.rready && rsp.rvalid) && n < 60);
      rr = isWr ? rsp.bresp : rsp.rresp;
      rv = rsp.rdata[7:0];
      req.bready <= 1'b0;
      req.rready <= 1'b0;
      if (n >= 60) begin
         errors++;
         final_report();
      end
   endtask : xfer

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [5:0] idx, input logic [7:0] e);
      xfer(1'b0, idx, 8'h00);
      chk({8'h0, rv}, {8'h0, e});
   endtask : rd

   task automatic readCount();
      xfer(1'b0, IDX_CNTH, 8'h00);
      cnt[15:8] = rv;
      xfer(1'b0, IDX_CNTL, 8'h00);
      cnt[7:0] = rv;
   endtask : readCount

   // n rising edges on the clock pin, ending low
   task automatic pulses(input int n);
      @(posedge clk);
      extRun <= 1'b1;
      repeat (4 * n) @(posedge clk);
      extRun <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulses

   // synchroniser plus edge detect need three edges; allow six
   task automatic pinSet(input int ch, input logic lvl);
      @(posedge clk);
      evtLevel[ch] <= lvl;
      repeat (6) @(posedge clk);
   endtask : pinSet

   initial begin
      rstn = 1'b0;
      req = '0;
      evtLevel = 2'h0;
      extRun = 1'b0;
      errors = 0;
      tests_run = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      foreach (rIdx[i]) rd(rIdx[i], rVal[i]);
      rd(6'h3f, 8'h00);
      chk({14'h0, rr}, {14'h0, RESP_ERR});
      wr(IDX_CH1C, 8'hff);
      rd(IDX_CH1C, 8'h5f);
      wr(IDX_CH1C, 8'h00);
      wr(IDX_MAIN, 8'h3f);
      rd(IDX_MAIN, 8'h27);
      chk({14'h0, rr}, {14'h0, RESP_OK});
      // write to the hole in the map: refused, no effect
      wr(6'h0b, 8'hff);
      chk({14'h0, rr}, {14'h0, RESP_ERR});
      $display("register map test done");
      // seven bus rates, counted over a fixed window
      for (int n = 0; n < 7; n++) begin
         wr(IDX_MAIN, 8'h30 | 8'(n));
         wr(IDX_MAIN, 8'(n));
         repeat (256) @(posedge clk);
         wr(IDX_MAIN, 8'h20 | 8'(n));
         readCount();
         ex = 16'(259 >> n);
         dif = (cnt > ex) ? cnt - ex : ex - cnt;
         chk((dif <= 3) ? ex : cnt, ex);
      end
      wr(IDX_MAIN, 8'h37);
      wr(IDX_MAIN, 8'h07);
      // reads while counting must not disturb the sequence
      fork
         pulses(20);
         repeat (5) xfer(1'b0, IDX_CNTL, 8'h00);
      join
      readCount();
      chk(cnt, 16'h0014);
      $display("prescaler test done");
      wr(IDX_WRAPH, 8'h00);
      wr(IDX_WRAPL, 8'h04);
      wr(IDX_MAIN, 8'h57);
      wr(IDX_IMASK, 8'h01);
      pulses(4);
      rd(IDX_MAIN, 8'h47);
      chk(irq, 1'b0);
      pulses(1);
      rd(IDX_MAIN, 8'hc7);
      readCount();
      chk(cnt, 16'h0000);
      chk(irq, 1'b1);
      wr(IDX_IMASK, 8'h00);
      chk(irq, 1'b0);
      wr(IDX_IMASK, 8'h03);
      chk(irq, 1'b1);
      wr(IDX_ISTAT, 8'h01);
      wr(IDX_MAIN, 8'h47);
      rd(IDX_MAIN, 8'h47);
      chk(irq, 1'b0);
      $display("overflow test done");
      pulses(3);
      wr(IDX_CH0C, 8'h44);
      pinSet(0, 1'b1);
      rd(IDX_CH0H, 8'h00);
      rd(IDX_CH0L, 8'h03);
      rd(IDX_CH0C, 8'hc4);
      chk(irq, 1'b1);
      wr(IDX_ISTAT, 8'h02);
      wr(IDX_CH0C, 8'h44);
      chk(irq, 1'b0);
      // every edge mode, both edge directions
      for (int m = 1; m < 4; m++) begin
         wr(IDX_CH1C, {4'h0, 2'(m), 2'h0});
         for (int e = 1; e >= 0; e--) begin
            pinSet(1, e[0]);
            xfer(1'b0, IDX_CH1C, 8'h00);
            chk(rv[7], e ? m[0] : m[1]);
            wr(IDX_CH1C, {4'h0, 2'(m), 2'h0});
         end
      end
      $display("capture test done");
      wr(IDX_MAIN, 8'h17);
      wr(IDX_WRAPL, 8'hff);
      wr(IDX_CH0H, 8'h00);
      // set, clear, toggle at successive compare values
      for (int k = 0; k < 3; k++) begin
         wr(IDX_CH0L, 8'(2 * k + 2));
         wr(IDX_CH0C, actCode[k]);
         pulses(2);
         chk(pinOut[0], k != 1);
         chk(pinIn[0], k != 1);
         chk(pinOeN[0], 1'b0);
      end
      wr(IDX_CH0L, 8'h80);
      wr(IDX_CH0C, 8'h16);
      wr(IDX_WRAPL, 8'h08);
      pulses(3);
      chk(pinOut[0], 1'b0);
      rd(IDX_MAIN, 8'h87);
      $display("compare test done");
      // linked pair: channel 1 value takes over after the next overflow
      wr(IDX_CH0L, 8'h02);
      wr(IDX_CH1L, 8'h05);
      wr(IDX_CH0C, 8'h34);
      pulses(2);
      chk(pinOut[0], 1'b1);
      chk(pinOeN[1], 1'b1);
      pulses(7);
      pulses(3);
      chk(pinOut[0], 1'b1);
      pulses(2);
      chk(pinOut[0], 1'b0);
      $display("link test done");
      final_report();
   end
endmodule : two_channel_capture_counter_tb
